// file: design/agd_config.v
// agd_config.v: general control and output format control register bank.
// assumes an internal byte register port from the serial front end, one
// cycle write strobe, and completion signals from the adc core.
`timescale 1ns/10ps
`include "agd_defines.vh"
module agd_config (
  input  wire        mclk_in,                 // 100 MHz clock
  input  wire        rst_n_in,                // async reset, low
  input  wire        reg_wr_in,               // write strobe, one cycle
  input  wire        reg_rd_in,               // read strobe, one cycle
  input  wire [7:0]  reg_addr_in,             // register address
  input  wire [7:0]  reg_wdata_in,            // write data
  input  wire        crc_err_set_in,          // inbound crc error seen
  input  wire        brownout_in,             // brownout or power cycle event
  input  wire        cal_done_in,             // offset calibration finished
  input  wire        frame_ninth_fall_in,     // 9th falling scl edge, pulse
  input  wire        conv_busy_in,            // conversion or averaging busy
  input  wire [11:0] adc_code_in,             // conversion result
  input  wire [3:0]  chan_id_in,              // channel of result
  input  wire [3:0]  status_flags_in,         // four status flags
  input  wire [7:0]  pin_cfg_in,              // pin config, 1 = gpio
  output reg  [7:0]  reg_rdata_out,           // read data
  output reg         rms_unit_enable_out,     // rms unit on
  output reg         rms_clear_out,           // clear rms results, pulse
  output reg         crc_enable_out,          // crc gen and check on
  output reg         statistics_enable_out,   // statistics updating on
  output reg         stats_clear_out,         // clear statistics, pulse
  output reg         window_comparator_rst_n_out, // comparator reset, low
  output reg         conv_start_out,          // start conversion, pulse
  output reg         scl_stretch_out,         // hold scl low
  output reg [7:0]   pin_cfg_eff_out,         // effective pin config
  output reg         offset_cal_start_out,    // launch calibration, pulse
  output reg         soft_reset_out,          // reset to rest of device
  output reg [15:0]  data_word_out,           // result with tag
  output reg [1:0]   tag_select_out           // tag field
);
  //////////////////////////////////////////////////////////////////////////
  reg  [7:0] gen_r;
  reg  [7:0] fmt_r;
  reg        crc_err_r;
  reg        brownout_flag_r;
  reg        trig_lvl_r;
  reg        srst_lvl_r;
  reg  [3:0] srst_cnt_r;
  reg        stretch_mode_r;
  localparam STR_IDLE  = 3'h1;
  localparam STR_START = 3'h2;
  localparam STR_BUSY  = 3'h4;
  reg  [2:0] brown_sync_r;
  reg  [2:0] str_state_r;
  reg  [2:0] str_state_nxt;
  wire       trig_pulse;
  wire       srst_pulse;
  wire       wr_blocked = crc_err_r && (reg_addr_in != `AGD_ADDR_STATUS)
                          && (reg_addr_in != `AGD_ADDR_GEN_CTRL);
  wire       wr_gen = reg_wr_in && !wr_blocked && (reg_addr_in == `AGD_ADDR_GEN_CTRL);
  wire       wr_fmt = reg_wr_in && !wr_blocked && (reg_addr_in == `AGD_ADDR_FMT_CTRL);
  wire       wr_sts = reg_wr_in && (reg_addr_in == `AGD_ADDR_STATUS);
  wire       srst_busy = (srst_cnt_r != 4'h0);
  wire       brownout_seen = brown_sync_r[1] & brown_sync_r[2];

  agd_pulse u_trig (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .level_in  (trig_lvl_r),
    .pulse_out (trig_pulse)
  );
  agd_pulse u_srst (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .level_in  (srst_lvl_r),
    .pulse_out (srst_pulse)
  );

  //////////////////////////////////////////////////////////////////////////
  // brownout detector runs off the clock: three flops, an event counts
  // once the second and third are both high
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      brown_sync_r <= 3'h0;
    end else begin
      brown_sync_r <= {brown_sync_r[1:0], brownout_in};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // scl hold: one cycle while the start pulse reaches the core, then until
  // the core drops busy; the core raises busy the cycle after a start
  always @* begin
    str_state_nxt = str_state_r;
    case (str_state_r)
      STR_IDLE: begin
        if (stretch_mode_r && frame_ninth_fall_in) begin
          str_state_nxt = STR_START;
        end
      end
      STR_START: begin
        str_state_nxt = STR_BUSY;
      end
      STR_BUSY: begin
        if (!conv_busy_in || !stretch_mode_r) begin
          str_state_nxt = STR_IDLE;
        end
      end
      default: begin
        str_state_nxt = STR_IDLE;
      end
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      str_state_r <= STR_IDLE;
    end else begin
      str_state_r <= str_state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register state
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gen_r           <= `AGD_GEN_RESET;
      fmt_r           <= `AGD_FMT_RESET;
      crc_err_r       <= 1'b0;
      brownout_flag_r <= 1'b1;
      trig_lvl_r      <= 1'b0;
      srst_lvl_r      <= 1'b0;
      srst_cnt_r      <= 4'h0;
      stretch_mode_r  <= 1'b1;
    end else begin
      trig_lvl_r <= wr_gen && !srst_busy && reg_wdata_in[`AGD_BIT_CONV_TRIG];
      srst_lvl_r <= wr_gen && !srst_busy && reg_wdata_in[`AGD_BIT_SOFT_RST];
      if (srst_pulse) begin
        srst_cnt_r <= `AGD_SRST_CYCLES;
      end else if (srst_busy) begin
        srst_cnt_r <= srst_cnt_r - 4'h1;
      end
      if (srst_busy) begin
        gen_r          <= `AGD_GEN_RESET;
        fmt_r          <= `AGD_FMT_RESET;
        crc_err_r      <= 1'b0;
        stretch_mode_r <= 1'b1;
        if (srst_cnt_r == 4'h1) begin
          brownout_flag_r <= 1'b1;
        end
      end else begin
        if (wr_gen) begin
          gen_r[7:4] <= reg_wdata_in[7:4];
          gen_r[`AGD_BIT_FORCE_ANA] <= reg_wdata_in[`AGD_BIT_FORCE_ANA];
          stretch_mode_r <= ~reg_wdata_in[`AGD_BIT_CONV_TRIG];
        end
        // an unrelated write must not swallow the done pulse
        if (wr_gen && reg_wdata_in[`AGD_BIT_OFFSET_CAL]) begin
          gen_r[`AGD_BIT_OFFSET_CAL] <= 1'b1;
        end else if (cal_done_in) begin
          gen_r[`AGD_BIT_OFFSET_CAL] <= 1'b0;
        end
        gen_r[`AGD_BIT_CONV_TRIG] <= 1'b0;
        gen_r[`AGD_BIT_SOFT_RST]  <= 1'b0;
        if (wr_fmt) begin
          fmt_r <= reg_wdata_in & `AGD_FMT_WR_MASK;
        end
        if (crc_err_set_in) begin
          crc_err_r <= 1'b1;
        end else if (wr_sts && reg_wdata_in[`AGD_BIT_CRC_ERR]) begin
          crc_err_r <= 1'b0;
        end
        if (brownout_seen) begin
          brownout_flag_r <= 1'b1;
        end else if (wr_sts && reg_wdata_in[`AGD_BIT_BROWNOUT]) begin
          brownout_flag_r <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  reg [15:0] data_nxt;
  always @* begin
    data_nxt = {adc_code_in, 4'h0};
    if (fmt_r[`AGD_BIT_CONST_CODE]) begin
      data_nxt[15:4] = `AGD_CONST_CODE;
    end
    case (fmt_r[`AGD_TAG_HI:`AGD_TAG_LO])
      `AGD_TAG_CHAN:  data_nxt[3:0] = chan_id_in;
      `AGD_TAG_FLAGS: data_nxt[3:0] = status_flags_in;
      default:        data_nxt[3:0] = 4'h0;
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out               <= 8'h00;
      rms_unit_enable_out         <= 1'b0;
      rms_clear_out               <= 1'b0;
      crc_enable_out              <= 1'b0;
      statistics_enable_out       <= 1'b0;
      stats_clear_out             <= 1'b0;
      window_comparator_rst_n_out <= 1'b0;
      conv_start_out              <= 1'b0;
      scl_stretch_out             <= 1'b0;
      pin_cfg_eff_out             <= 8'h00;
      offset_cal_start_out        <= 1'b0;
      soft_reset_out              <= 1'b0;
      data_word_out               <= 16'h0000;
      tag_select_out              <= 2'h0;
    end else begin
      if (reg_rd_in) begin
        case (reg_addr_in)
          `AGD_ADDR_STATUS:   reg_rdata_out <= `AGD_STATUS_RSVD | {6'h00, crc_err_r, brownout_flag_r};
          `AGD_ADDR_GEN_CTRL: reg_rdata_out <= gen_r & 8'hF6;
          `AGD_ADDR_FMT_CTRL: reg_rdata_out <= fmt_r & `AGD_FMT_WR_MASK;
          default:            reg_rdata_out <= 8'h00;
        endcase
      end
      rms_unit_enable_out   <= gen_r[`AGD_BIT_RMS_UNIT_ENABLE];
      rms_clear_out         <= wr_gen && !srst_busy && reg_wdata_in[`AGD_BIT_RMS_UNIT_ENABLE];
      crc_enable_out        <= gen_r[`AGD_BIT_CRC_EN];
      statistics_enable_out <= gen_r[`AGD_BIT_STATISTICS_ENABLE];
      stats_clear_out       <= wr_gen && !srst_busy && reg_wdata_in[`AGD_BIT_STATISTICS_ENABLE];
      window_comparator_rst_n_out <= gen_r[`AGD_BIT_WINDOW_EN];
      conv_start_out        <= trig_pulse || (stretch_mode_r && frame_ninth_fall_in);
      scl_stretch_out       <= (str_state_nxt != STR_IDLE);
      pin_cfg_eff_out       <= gen_r[`AGD_BIT_FORCE_ANA] ? 8'h00 : pin_cfg_in;
      offset_cal_start_out  <= wr_gen && !srst_busy && reg_wdata_in[`AGD_BIT_OFFSET_CAL];
      soft_reset_out        <= srst_busy;
      data_word_out         <= data_nxt;
      tag_select_out        <= fmt_r[`AGD_TAG_HI:`AGD_TAG_LO];
    end
  end
endmodule // agd_config

// file: design/agd_defines.vh
// agd_defines.vh: offsets, field positions, reset values and codes for the
// general control and output format control registers.
// assumes an internal register port driven by the serial front end.
//
// Summary of operation
// - rms enable write clears results, restarts
// - check enable adds and verifies crc
// - statistics enable clears, then updates statistics
// - comparator held reset while enable zero
// - conversion trigger reads back as zero
// - normal mode converts at 9th edge, stretches
// - trigger write converts without clock stretching
// - force analog overrides pin configuration
// - offset trim bit clears when done
// - soft reset restores defaults, sets brownout
// - constant code outputs fixed 0xA5A
// - tag select chooses appended data
// - reserved format bits read zero
// - crc error blocks writes except 0x00/0x01
// - brownout flag cleared only by writing one
`ifndef AGD_DEFINES_VH
`define AGD_DEFINES_VH
`define AGD_ADDR_STATUS      8'h00
`define AGD_ADDR_GEN_CTRL    8'h01
`define AGD_ADDR_FMT_CTRL    8'h02
`define AGD_GEN_RESET        8'h00
`define AGD_FMT_RESET        8'h00
`define AGD_STATUS_RSVD      8'h80
`define AGD_BIT_RMS_UNIT_ENABLE       7
`define AGD_BIT_CRC_EN       6
`define AGD_BIT_STATISTICS_ENABLE     5
`define AGD_BIT_WINDOW_EN    4
`define AGD_BIT_CONV_TRIG    3
`define AGD_BIT_FORCE_ANA    2
`define AGD_BIT_OFFSET_CAL   1
`define AGD_BIT_SOFT_RST     0
`define AGD_BIT_CONST_CODE   7
`define AGD_TAG_HI           5
`define AGD_TAG_LO           4
`define AGD_FMT_WR_MASK      8'hB0
`define AGD_BIT_CRC_ERR      1
`define AGD_BIT_BROWNOUT     0
`define AGD_CONST_CODE       12'hA5A
`define AGD_TAG_NONE         2'h0
`define AGD_TAG_CHAN         2'h1
`define AGD_TAG_FLAGS        2'h2
`define AGD_SRST_CYCLES      4'h4
`endif

// file: design/agd_pulse.v
// agd_pulse.v: one-cycle pulse on the rising edge of a level.
// assumes level is synchronous to mclk_in.
`timescale 1ns/10ps
module agd_pulse (
  input  wire mclk_in,    // clock
  input  wire rst_n_in,   // async reset, low
  input  wire level_in,   // level to watch
  output reg  pulse_out   // one-cycle pulse
);
  reg last_r;
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_r    <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      last_r    <= level_in;
      pulse_out <= level_in & ~last_r;
    end
  end
endmodule // agd_pulse

// file: testbench/agd_core_model.sv
// agd_core_model.sv: adc core stand-in, busy after a start, calibration done later.
// assumes start pulses synchronous to mclk_in.
`timescale 1ns/10ps
module agd_core_model (
  input  wire mclk_in,     // clock
  input  wire rst_n_in,    // reset, low
  input  wire conv_in,     // conversion start
  input  wire cal_in,      // calibration start
  output wire busy_out,    // conversion running
  output wire cal_done_out // calibration done
);
  reg [7:0] conv_sr_r, cal_sr_r;
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      conv_sr_r <= 8'h00;
      cal_sr_r  <= 8'h00;
    end else begin
      conv_sr_r <= {conv_sr_r[6:0], conv_in};
      cal_sr_r  <= {cal_sr_r[6:0], cal_in};
    end
  end
  assign busy_out     = |conv_sr_r[5:0];
  assign cal_done_out = cal_sr_r[7];
endmodule // agd_core_model

// file: testbench/agd_config_checker.sv
// agd_config_checker.sv: port assertions for agd_config.
// assumes it is bound into agd_config.
`timescale 1ns/10ps
module agd_config_checker (
  input wire       mclk_in,                     // clock
  input wire       rst_n_in,                    // reset, low
  input wire       reg_wr_in,                   // write strobe
  input wire       reg_rd_in,                   // read strobe
  input wire       frame_ninth_fall_in,         // ninth edge pulse
  input wire [7:0] reg_addr_in,                 // register address
  input wire [7:0] reg_wdata_in,                // write data
  input wire [7:0] reg_rdata_out,               // read data
  input wire       rms_clear_out,               // rms clear pulse
  input wire       crc_enable_out,              // crc on
  input wire       stats_clear_out,             // statistics clear pulse
  input wire       window_comparator_rst_n_out, // comparator reset, low
  input wire       offset_cal_start_out,        // calibration launch
  input wire       scl_stretch_out,             // scl hold
  input wire       soft_reset_out,              // soft reset level
  input wire       conv_start_out               // conversion start
);
  wire [7:0] wb = {8{reg_wr_in && reg_addr_in == 8'h01}} & reg_wdata_in;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  property p_rms; rms_clear_out |-> $past(wb[7]) || $past(wb[7], 2); endproperty
  a_rms: assert property (p_rms) else $error("rms clear");
  property p_crc; $rose(crc_enable_out) |-> $past(wb[6]) || $past(wb[6], 2); endproperty
  a_crc: assert property (p_crc) else $error("crc enable");
  property p_sta; stats_clear_out |-> $past(wb[5]) || $past(wb[5], 2); endproperty
  a_sta: assert property (p_sta) else $error("stats clear");
  property p_win; $rose(window_comparator_rst_n_out) |-> $past(wb[4]) || $past(wb[4], 2); endproperty
  a_win: assert property (p_win) else $error("window enable");
  property p_cal; offset_cal_start_out |-> $past(wb[1]) || $past(wb[1], 2); endproperty
  a_cal: assert property (p_cal) else $error("cal start");
  property p_rd; reg_rd_in && reg_addr_in == 8'h01 |=> (reg_rdata_out & 8'h09) == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("ctrl readback");
  property p_str; $rose(scl_stretch_out) |-> $past(frame_ninth_fall_in) || $past(frame_ninth_fall_in, 2); endproperty
  a_str: assert property (p_str) else $error("stretch cause");
  property p_sst; $rose(scl_stretch_out) |-> conv_start_out; endproperty
  a_sst: assert property (p_sst) else $error("stretch without start");
  property p_srs; $rose(soft_reset_out) |-> soft_reset_out [*4] ##1 !soft_reset_out; endproperty
  a_srs: assert property (p_srs) else $error("soft reset length");
  cover property (conv_start_out);
  cover property ($rose(soft_reset_out));
  cover property ($fell(scl_stretch_out));
endmodule // agd_config_checker
bind agd_config agd_config_checker u_chk (.*);

// file: testbench/agd_config_tb.sv
// agd_config_tb.sv: self-checking bench for agd_config.
// assumes agd_core_model and the bound checker.
`timescale 1ns/10ps
module agd_config_tb;
  reg mclk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, crc_err_set_in = 0, brownout_in = 0;
  reg frame_ninth_fall_in = 0;
  reg [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, pin_cfg_in = 8'hC3;
  reg [11:0] adc_code_in = 12'h123;
  reg [3:0] chan_id_in = 4'h6, status_flags_in = 4'h9;
  wire [7:0] reg_rdata_out, pin_cfg_eff_out;
  wire [15:0] data_word_out;
  wire [1:0] tag_select_out;
  wire cal_done_in, conv_busy_in, rms_unit_enable_out, rms_clear_out, crc_enable_out, statistics_enable_out;
  wire stats_clear_out, window_comparator_rst_n_out, conv_start_out, scl_stretch_out, offset_cal_start_out;
  wire soft_reset_out;
  integer err_count = 0, tests_run = 0, cycles = 0, m, n, t;
  agd_config dut (.*);
  agd_core_model u_core (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .conv_in(conv_start_out),
    .cal_in(offset_cal_start_out), .busy_out(conv_busy_in), .cal_done_out(cal_done_in));
  initial forever #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  ////////////////////////////////////////////////////////////
  task final_report;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cyc; @(posedge mclk_in) #1; endtask
  task chk(input [63:0] got, input [63:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
    cyc;
    reg_wr_in = 0;
    cyc;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    {reg_addr_in, reg_rd_in} = {a, 1'b1};
    cyc;
    reg_rd_in = 0;
    cyc;
    chk(reg_rdata_out, e);
  endtask
  task frm(input f);
    {frame_ninth_fall_in, m, n} = {f, 64'h0};
    repeat (14) begin
      cyc;
      frame_ninth_fall_in = 0;
      m = m + conv_start_out;
      n = n + scl_stretch_out;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task t_status;
    rd(8'h00, 8'h81);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h81);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h80);
    brownout_in = 1;
    repeat (4) cyc;
    brownout_in = 0;
    repeat (2) cyc;
    rd(8'h00, 8'h81);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h80);
  endtask
  task t_general;
    wr(8'h01, 8'hF4);
    chk({rms_unit_enable_out, crc_enable_out, statistics_enable_out, window_comparator_rst_n_out}, 4'hF);
    chk(pin_cfg_eff_out, 8'h00);
    rd(8'h01, 8'hF4);
    wr(8'h01, 8'h00);
    chk({window_comparator_rst_n_out, pin_cfg_eff_out}, 9'h0C3);
  endtask
  task t_format;
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'hB0);
    wr(8'h03, 8'h55);
    rd(8'h03, 8'h00);
  endtask
  task t_crc_block;
    crc_err_set_in = 1;
    cyc;
    crc_err_set_in = 0;
    rd(8'h00, 8'h82);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'hB0);
    wr(8'h01, 8'h04);
    rd(8'h01, 8'h04);
    wr(8'h00, 8'h02);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00);
  endtask
  task t_tags;
    for (t = 0; t < 3; t = t + 1) begin
      wr(8'h02, {2'h2, t[1:0], 4'h0});
      cyc;
      chk(tag_select_out, t[1:0]);
      chk(data_word_out, {12'hA5A, t == 0 ? 4'h0 : t == 1 ? chan_id_in : status_flags_in});
    end
    wr(8'h02, 8'h10);
    cyc;
    chk(data_word_out, {adc_code_in, chan_id_in});
  endtask
  task t_trigger;
    wr(8'h01, 8'h08);
    frm(0);
    chk({m, n}, 64'h1_0000_0000);
    frm(1);
    chk(n, 0);
    chk(m, 0);
    wr(8'h01, 8'h00);
    frm(1);
    chk(m, 1);
    chk(n > 3, 1);
    chk(scl_stretch_out, 0);
  endtask
  task t_cal;
    wr(8'h01, 8'h02);
    rd(8'h01, 8'h02);
    repeat (12) cyc;
    rd(8'h01, 8'h00);
    // second run: a plain write lands with the done pulse
    wr(8'h01, 8'h02);
    repeat (7) cyc;
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
  endtask
  task t_soft_reset;
    wr(8'h01, 8'hF5);
    repeat (8) cyc;
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h00, 8'h81);
    frm(1);
    chk(m, 1);
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    #1 rst_n_in = 1;
    t_status;
    t_general;
    t_format;
    t_crc_block;
    t_tags;
    t_trigger;
    t_cal;
    t_soft_reset;
    final_report;
  end
endmodule // agd_config_tb
